// [verilog/mad_pkg.sv]
// Shared constants and types for the mirror array device and controller.
// Assumes one 100 MHz clock shared by both ends.
package mad_pkg;
    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int NUM_COLS = 912; // Active columns
    localparam int NUM_ROWS = 1140; // Active rows
    localparam int BORDER = 10; // Off-state band per side
    localparam int BUS_W = 24; // DDR bus width
    localparam int BEAT_W = 2 * BUS_W; // Rise plus fall half
    localparam int BEATS_PER_COL = 24; // 24 beats x 48 bits >= 1140
    localparam int NUM_WORDS = NUM_COLS * BEATS_PER_COL;
    localparam int COL_W = 10; // Active column index width
    localparam int BEAT_IDX_W = 5;
    localparam int WORD_W = 15; // Storage word index width
    localparam int QCOL_W = 10; // Column incl. border
    localparam int QROW_W = 11; // Row incl. border
    localparam int BIT_W = 6; // Bit within a beat
    // ************************************************************
    // Serial control frames: {op, column}
    // ************************************************************
    localparam int OP_W = 2;
    localparam int FRAME_BITS = OP_W + COL_W;
    localparam int FCNT_W = 4;
    typedef enum logic [OP_W-1:0] {
        OP_NOP, OP_COLSEL, OP_MIRCLK, OP_PARK
    } mad_op_t;
    // Reported mirror position
    typedef enum logic [1:0] {
        TILT_FLAT, TILT_ON, TILT_OFF
    } mad_tilt_t;
    // ************************************************************
    // Pattern rates
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int STREAM_RATE_HZ = 2880;
    localparam int BURST_RATE_HZ = 4220;
    // Least pattern period rounds up
    localparam int STREAM_GAP_CYC =
        (CLK_HZ + STREAM_RATE_HZ - 1) / STREAM_RATE_HZ;
    localparam int BURST_GAP_CYC =
        (CLK_HZ + BURST_RATE_HZ - 1) / BURST_RATE_HZ;
    localparam int GAP_W = 16;
    localparam int BURST_MAX = 48; // Patterns held for a burst
    localparam int PCNT_W = 6;
endpackage : mad_pkg

// [verilog/mad_link_if.sv]
// Link between controller and mirror array device.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mad_link_if;
    import mad_pkg::*;
    logic ctlEn; // Serial control frame bit valid
    logic ctlBit; // Serial control bit, MSB first
    logic dataValid; // Pixel beat valid
    logic [BUS_W-1:0] dataRise; // Rising-edge half
    logic [BUS_W-1:0] dataFall; // Falling-edge half
    logic busy; // Mirror clocking sweep running
    modport dev (input ctlEn, ctlBit, dataValid, dataRise, dataFall,
        output busy);
    modport ctl (output ctlEn, ctlBit, dataValid, dataRise, dataFall,
        input busy);
endinterface : mad_link_if

// [verilog/mad_mirror_array_device.sv]
// Mirror array device end: cell storage, mirror state, park, border.
// Assumes a controller on the link that keeps the update order.
// Contract
// - 912 x 1140 one-bit cells, one per mirror
// - Columns written one at a time, 24-bit DDR
// - Column select via serial control bus only
// - Cell one lands +12, zero lands -12
// - Mirrors move only on clocking pulse
// - Controller writes all, then one pulse
// - Device makes reset pulses, controller starts them
// - Parked mirrors flat, parked not latched
// - Ten border mirrors per side, off after power
// - Controller maps for diamond half-pixel offset; this controller takes data already mapped upstream
// - Stream mode 24-bit, 2880 Hz, unlimited
// - Burst up to 48 patterns, 4220 Hz
`timescale 1ns/100ps
module mad_mirror_array_device import mad_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    mad_link_if.dev link,
    input wire logic [QCOL_W-1:0] qCol,
    input wire logic [QROW_W-1:0] qRow,
    output mad_tilt_t qTilt,
    output logic parked
);
    // ************************************************************
    // Storage
    // ************************************************************
    // Written cells, one bit per active mirror
    logic [BEAT_W-1:0] cells [0:NUM_WORDS-1];
    // Landed mirror positions, copied by the clocking sweep
    logic [BEAT_W-1:0] landed [0:NUM_WORDS-1];

    // Frame receiver
    logic [FRAME_BITS-2:0] shift_q; // Serial frame bits so far
    logic [FCNT_W-1:0] bitCnt_q; // Bits received in frame
    // Write pointers
    logic [COL_W-1:0] col_q; // Selected column
    logic [BEAT_IDX_W-1:0] beat_q; // Beat within column
    // Sweep state
    logic busy_q; // Sweep running
    logic [WORD_W-1:0] sweep_q; // Sweep word index
    // Park and power
    logic parked_q; // Park state
    logic powered_q; // Set after first edge out of reset
    // Frame decode
    logic frameDone; // Last frame bit arrives
    logic [FRAME_BITS-1:0] frame; // Whole frame
    mad_op_t op; // Decoded op
    logic [COL_W-1:0] frameCol; // Decoded column

    // Word index of a beat within the storage
    function automatic logic [WORD_W-1:0] wordIdx(
        input logic [COL_W-1:0] c, input logic [BEAT_IDX_W-1:0] b);
        logic [WORD_W-1:0] base;
        base = WORD_W'(c) * WORD_W'(BEATS_PER_COL);
        return WORD_W'(base + WORD_W'(b));
    endfunction : wordIdx

    // ************************************************************
    // Serial control bus
    // ************************************************************
    // Last bit ends frame
    assign frameDone = link.ctlEn
        && (bitCnt_q == FCNT_W'(FRAME_BITS - 1));
    assign frame = {shift_q, link.ctlBit};
    assign op = mad_op_t'(frame[FRAME_BITS-1 -: OP_W]);
    assign frameCol = frame[COL_W-1:0];

    // Shift in frame bits, MSB first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            bitCnt_q <= '0;
        end else if (link.ctlEn) begin
            shift_q <= frame[FRAME_BITS-2:0];
            // Wrap after a full frame
            bitCnt_q <= frameDone ? '0 : bitCnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Column addressing and writes
    // ************************************************************
    // Column chosen only by a control frame, never by pixel data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= '0;
            beat_q <= '0;
        end else if (frameDone && op == OP_COLSEL) begin
            col_q <= frameCol;
            beat_q <= '0;
        end else if (link.dataValid) begin
            // Extra beats past the column wrap onto its start
            if (beat_q == BEAT_IDX_W'(BEATS_PER_COL - 1)) begin
                beat_q <= '0;
            end else begin
                beat_q <= beat_q + 1'b1;
            end
        end
    end

    // Store a DDR beat into the selected column; mirrors untouched
    // Cells not reset
    always_ff @(posedge clk) begin
        if (link.dataValid) begin
            cells[wordIdx(col_q, beat_q)] <=
                {link.dataFall, link.dataRise};
        end
    end

    // ************************************************************
    // Mirror clocking sweep
    // ************************************************************
    // Device times the pulse itself; the frame only starts it
    // No restart mid-sweep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            sweep_q <= '0;
        end else if (busy_q) begin
            if (sweep_q == WORD_W'(NUM_WORDS - 1)) begin
                busy_q <= 1'b0;
            end
            sweep_q <= sweep_q + 1'b1;
        end else if (frameDone && op == OP_MIRCLK) begin
            busy_q <= 1'b1;
            sweep_q <= '0;
        end
    end
    assign link.busy = busy_q;

    // Copy cells to mirrors one word a cycle; a real pulse is global,
    // so writes during the sweep may land partly (controller waits)
    always_ff @(posedge clk) begin
        if (busy_q) begin
            landed[sweep_q] <= cells[sweep_q];
        end
    end

    // ************************************************************
    // Park and power state
    // ************************************************************
    // Park lasts only until the next clocking frame ends and starts the sweep
    // Park keeps data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parked_q <= 1'b1;
        end else if (frameDone && op == OP_MIRCLK) begin
            parked_q <= 1'b0;
        end else if (frameDone && op == OP_PARK) begin
            parked_q <= 1'b1;
        end
    end
    assign parked = parked_q;

    // Border lands off once power is up
    // Wired, no cells
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powered_q <= 1'b0;
        end else begin
            powered_q <= 1'b1;
        end
    end

    // ************************************************************
    // Mirror position readout
    // ************************************************************
    // Query decode
    logic inBorder; // Query falls on border band
    logic [COL_W-1:0] aCol; // Active column
    logic [QROW_W-1:0] aRow; // Active row
    logic [BEAT_IDX_W-1:0] aBeat; // Beat holding the row
    logic [BIT_W-1:0] aBit; // Bit within beat
    logic [BEAT_W-1:0] aWord; // Landed word

    // Border band sits outside the addressable grid
    // Off-grid reads unused
    always_comb begin
        inBorder = (qCol < QCOL_W'(BORDER))
            || (qCol >= QCOL_W'(BORDER + NUM_COLS))
            || (qRow < QROW_W'(BORDER))
            || (qRow >= QROW_W'(BORDER + NUM_ROWS));
        aCol = COL_W'(qCol - QCOL_W'(BORDER));
        aRow = qRow - QROW_W'(BORDER);
        aBeat = BEAT_IDX_W'(aRow / QROW_W'(BEAT_W));
        aBit = BIT_W'(aRow % QROW_W'(BEAT_W));
        aWord = landed[wordIdx(aCol, aBeat)];
    end

    // Registered tilt: border off, parked flat, else landed bit
    // Band before park
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qTilt <= TILT_FLAT;
        end else if (inBorder) begin
            qTilt <= powered_q ? TILT_OFF : TILT_FLAT;
        end else if (parked_q) begin
            qTilt <= TILT_FLAT;
        end else if (aWord[aBit]) begin
            qTilt <= TILT_ON;
        end else begin
            qTilt <= TILT_OFF;
        end
    end
endmodule : mad_mirror_array_device

// [verilog/mad_pattern_controller.sv]
// Controller end: streams patterns column by column, rate limited.
// Assumes user data already mapped to cell order.
`timescale 1ns/100ps
module mad_pattern_controller import mad_pkg::*; #(
    parameter int STREAM_GAP = STREAM_GAP_CYC,
    parameter int BURST_GAP = BURST_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    mad_link_if.ctl link,
    input wire logic burstMode,
    input wire logic burstRestart,
    input wire logic parkReq,
    input wire logic userValid,
    output logic userReady,
    input wire logic [BEAT_W-1:0] userData,
    output logic [PCNT_W-1:0] burstCount,
    output logic patDone
);
    typedef enum logic [1:0] {C_IDLE, C_SEND, C_DATA, C_WAIT} mad_cst_t;
    mad_cst_t st_q; // Controller state
    mad_op_t sendOp_q; // Frame being sent
    logic [FRAME_BITS-1:0] sh_q; // Outgoing frame bits
    logic [FCNT_W-1:0] cnt_q; // Bits shown so far
    logic [COL_W-1:0] col_q; // Column being written
    logic [BEAT_IDX_W-1:0] beat_q; // Beat in column
    logic [GAP_W-1:0] gap_q; // Pattern period timer
    logic [PCNT_W-1:0] pcnt_q; // Burst patterns sent
    logic parkPend_q; // Park waiting for idle
    logic burstFull;
    logic startPat;
    logic lastBeat;

    assign burstFull = burstMode && (pcnt_q == PCNT_W'(BURST_MAX));
    assign startPat = st_q == C_IDLE && !parkPend_q && userValid
        && gap_q == '0 && !burstFull;
    assign userReady = st_q == C_DATA;
    assign lastBeat = beat_q == BEAT_IDX_W'(BEATS_PER_COL - 1);
    assign burstCount = pcnt_q;

    // Top bit of an op
    function automatic logic opMsb(input mad_op_t o);
        return o[OP_W-1];
    endfunction : opMsb

    // ************************************************************
    // Sequencer and serial frames
    // ************************************************************
    // Frames shift out MSB first, one bit a cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= C_IDLE;
            sendOp_q <= OP_NOP;
            sh_q <= '0;
            cnt_q <= '0;
            col_q <= '0;
            beat_q <= '0;
            link.ctlEn <= 1'b0;
            link.ctlBit <= 1'b0;
        end else begin
            unique case (st_q)
                C_IDLE: begin
                    if (parkPend_q) begin
                        st_q <= C_SEND;
                        sendOp_q <= OP_PARK;
                        sh_q <= {OP_PARK, COL_W'(0)} << 1;
                        link.ctlBit <= opMsb(OP_PARK);
                        link.ctlEn <= 1'b1;
                        cnt_q <= FCNT_W'(1);
                    end else if (startPat) begin
                        st_q <= C_SEND;
                        sendOp_q <= OP_COLSEL;
                        col_q <= '0;
                        sh_q <= {OP_COLSEL, COL_W'(0)} << 1;
                        link.ctlBit <= opMsb(OP_COLSEL);
                        link.ctlEn <= 1'b1;
                        cnt_q <= FCNT_W'(1);
                    end
                end
                C_SEND: begin
                    if (cnt_q == FCNT_W'(FRAME_BITS)) begin
                        link.ctlEn <= 1'b0;
                        beat_q <= '0;
                        unique case (sendOp_q)
                            OP_COLSEL: st_q <= C_DATA;
                            OP_MIRCLK: st_q <= C_WAIT;
                            default: st_q <= C_IDLE;
                        endcase
                    end else begin
                        link.ctlBit <= sh_q[FRAME_BITS-1];
                        sh_q <= sh_q << 1;
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                C_DATA: begin
                    if (userValid) begin
                        beat_q <= beat_q + 1'b1;
                        if (lastBeat) begin
                            st_q <= C_SEND;
                            link.ctlEn <= 1'b1;
                            cnt_q <= FCNT_W'(1);
                            // Pulse only after the last column
                            if (col_q == COL_W'(NUM_COLS - 1)) begin
                                sendOp_q <= OP_MIRCLK;
                                sh_q <= {OP_MIRCLK, COL_W'(0)} << 1;
                                link.ctlBit <= opMsb(OP_MIRCLK);
                            end else begin
                                sendOp_q <= OP_COLSEL;
                                sh_q <= {OP_COLSEL, col_q + 1'b1} << 1;
                                link.ctlBit <= opMsb(OP_COLSEL);
                                col_q <= col_q + 1'b1;
                            end
                        end
                    end
                end
                C_WAIT: begin
                    // Device runs its own pulse; wait it out
                    if (!link.busy) begin
                        st_q <= C_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Pixel beats
    // ************************************************************
    // Data passes in cell order; diamond offset mapped upstream
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.dataValid <= 1'b0;
            link.dataRise <= '0;
            link.dataFall <= '0;
        end else begin
            link.dataValid <= userReady && userValid;
            if (userReady && userValid) begin
                link.dataRise <= userData[BUS_W-1:0];
                link.dataFall <= userData[BEAT_W-1:BUS_W];
            end
        end
    end

    // ************************************************************
    // Rate limit, burst count, park request
    // ************************************************************
    // Period timer caps pattern rate per mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= '0;
        end else if (startPat) begin
            gap_q <= burstMode ? GAP_W'(BURST_GAP - 1)
                : GAP_W'(STREAM_GAP - 1);
        end else if (gap_q != '0) begin
            gap_q <= gap_q - 1'b1;
        end
    end

    // Burst count; stream mode never stops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_q <= '0;
            patDone <= 1'b0;
        end else begin
            patDone <= st_q == C_WAIT && !link.busy;
            if (burstRestart) begin
                pcnt_q <= '0;
            end else if (st_q == C_WAIT && !link.busy && burstMode) begin
                pcnt_q <= pcnt_q + 1'b1;
            end
        end
    end

    // Request set wins over its own clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parkPend_q <= 1'b0;
        end else if (parkReq) begin
            parkPend_q <= 1'b1;
        end else if (st_q == C_IDLE) begin
            parkPend_q <= 1'b0;
        end
    end
endmodule : mad_pattern_controller

// [bench/mad_link_chk.sv]
// Checker on the link between pattern controller and mirror device.
// Assumes the link signals and the shared clock and reset as inputs.
`timescale 1ns/100ps
module mad_link_chk import mad_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctlEn,
    input wire logic ctlBit,
    input wire logic dataValid,
    input wire logic [BUS_W-1:0] dataRise,
    input wire logic [BUS_W-1:0] dataFall,
    input wire logic busy
);
    // ******************************************************
    // Frame and sweep trackers
    // ******************************************************
    logic [FCNT_W-1:0] bitCnt_q; // Bit position in frame
    logic [FRAME_BITS-2:0] shift_q; // Bits taken so far
    logic [BEAT_IDX_W-1:0] beatCnt_q; // Beats since column select
    logic [COL_W-1:0] colCnt_q; // Columns since last pulse
    logic [14:0] busyRun_q; // Cycles of current sweep
    wire lastBit = ctlEn && (bitCnt_q == 4'(FRAME_BITS - 1));
    wire [OP_W-1:0] op = shift_q[FRAME_BITS-2 -: OP_W];
    wire colEnd = lastBit && (op == OP_COLSEL); // Column select done
    wire clkEnd = lastBit && (op == OP_MIRCLK); // Clocking pulse asked

    // Bit count; frames may run back to back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) bitCnt_q <= '0;
        else if (lastBit) bitCnt_q <= '0;
        else if (ctlEn) bitCnt_q <= bitCnt_q + 4'h1;
    end
    // Frame bits, first bit lands on top
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) shift_q <= '0;
        else if (ctlEn) shift_q <= {shift_q[FRAME_BITS-3:0], ctlBit};
    end
    // Starts full, so a beat before any select is caught
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) beatCnt_q <= 5'h18;
        else if (colEnd) beatCnt_q <= '0;
        else if (dataValid) beatCnt_q <= beatCnt_q + 5'h1;
    end
    // Columns selected since the last pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) colCnt_q <= '0;
        else if (clkEnd) colCnt_q <= '0;
        else if (colEnd) colCnt_q <= colCnt_q + 10'h1;
    end
    // Sweep length counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) busyRun_q <= '0;
        else if (busy) busyRun_q <= busyRun_q + 15'h1;
        else busyRun_q <= '0;
    end

    // ******************************************************
    // Properties
    // ******************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_busy_no_data;
        busy |-> !dataValid;
    endproperty
    property p_busy_no_frame;
        busy |-> !ctlEn;
    endproperty
    property p_frame_whole;
        $fell(ctlEn) |-> bitCnt_q == '0;
    endproperty
    property p_sweep_len;
        $fell(busy) |-> busyRun_q == 15'(NUM_WORDS);
    endproperty
    property p_sweep_start;
        clkEnd |=> busy;
    endproperty
    property p_sweep_cause;
        $rose(busy) |-> $past(clkEnd);
    endproperty
    property p_beat_in_col;
        dataValid |-> beatCnt_q < 5'h18;
    endproperty
    property p_pulse_after_all;
        clkEnd |-> colCnt_q == 10'(NUM_COLS) && beatCnt_q == 5'h18;
    endproperty
    a_busy_no_data: assert property (p_busy_no_data)
        else $error("pixel beat during sweep");
    a_busy_no_frame: assert property (p_busy_no_frame)
        else $error("control frame during sweep");
    a_frame_whole: assert property (p_frame_whole)
        else $error("control frame cut short");
    a_sweep_len: assert property (p_sweep_len)
        else $error("sweep length wrong");
    a_sweep_start: assert property (p_sweep_start)
        else $error("no sweep after clocking frame");
    a_sweep_cause: assert property (p_sweep_cause)
        else $error("sweep without clocking frame");
    a_beat_in_col: assert property (p_beat_in_col)
        else $error("beat outside a selected column");
    a_pulse_after_all: assert property (p_pulse_after_all)
        else $error("clocking frame before array written");
    c_colsel: cover property (colEnd);
    c_sweep_done: cover property ($fell(busy));
    c_beat: cover property (dataValid && (dataRise != dataFall));
endmodule : mad_link_chk

// [bench/mad_tb.sv]
// Bench joining controller and mirror device over the link.
// Assumes 100 MHz; one full pattern and sweep take about 55k cycles.
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        failCount++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module mad_tb import mad_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic burstMode = 1'b0; // Set for the one pattern sent
    logic burstRestart = 1'b0;
    logic parkReq = 1'b0;
    logic userValid = 1'b0;
    logic userReady;
    logic [BEAT_W-1:0] userData;
    logic [PCNT_W-1:0] burstCount;
    logic patDone;
    logic [QCOL_W-1:0] qCol = '0;
    logic [QROW_W-1:0] qRow = '0;
    mad_tilt_t qTilt;
    logic parked;
    int failCount = 0;
    int comparisons = 0;
    int drvCol = 0; // Column the source is feeding
    int drvBeat = 0;
    logic [FRAME_BITS-2:0] mSh = '0; // Monitor frame bits
    logic [FRAME_BITS-1:0] mFrame;
    logic [OP_W-1:0] mExp;
    int mCnt = 0;
    int mFrames = 0;
    int mCol = 0;
    int mBeat = 0;
    int beatsSeen = 0;
    int tc[6] = '{0, 0, 911, 455, 1, 1}; // Active cells probed
    int tr[6] = '{0, 1, 1139, 600, 47, 48};
    int bc[6] = '{0, 931, 5, 500, 9, 922}; // Border cells probed
    int br[6] = '{0, 1159, 500, 1155, 9, 1150};

    // Cell content of the test pattern
    function automatic logic cellBit(input int c, input int r);
        return ((c + r) % 3) == 0;
    endfunction : cellBit
    function automatic logic [BEAT_W-1:0] beatData(input int c, int b);
        logic [BEAT_W-1:0] v;
        for (int k = 0; k < BEAT_W; k++) v[k] = cellBit(c, b * BEAT_W + k);
        return v;
    endfunction : beatData

    // ******************************************************
    // Design under test
    // ******************************************************
    mad_link_if mad_link_if_i ();
    mad_pattern_controller #(.STREAM_GAP(4), .BURST_GAP(4))
        mad_pattern_controller_i (.clk(clk), .rst_n(rst_n),
        .link(mad_link_if_i.ctl), .burstMode(burstMode),
        .burstRestart(burstRestart), .parkReq(parkReq),
        .userValid(userValid), .userReady(userReady),
        .userData(userData), .burstCount(burstCount), .patDone(patDone));
    mad_mirror_array_device mad_mirror_array_device_i (.clk(clk),
        .rst_n(rst_n), .link(mad_link_if_i.dev), .qCol(qCol),
        .qRow(qRow), .qTilt(qTilt), .parked(parked));
    mad_link_chk mad_link_chk_i (.clk(clk), .rst_n(rst_n),
        .ctlEn(mad_link_if_i.ctlEn), .ctlBit(mad_link_if_i.ctlBit),
        .dataValid(mad_link_if_i.dataValid),
        .dataRise(mad_link_if_i.dataRise),
        .dataFall(mad_link_if_i.dataFall), .busy(mad_link_if_i.busy));

    initial begin
        forever #5 clk = ~clk;
    end
    // Source: one whole pattern, then the valid drops
    always @(posedge clk) begin
        if (userValid && userReady) begin
            if (drvBeat == BEATS_PER_COL - 1) begin
                drvBeat <= 0;
                drvCol <= drvCol + 1;
                if (drvCol == NUM_COLS - 1) userValid <= 1'b0;
            end else begin
                drvBeat <= drvBeat + 1;
            end
        end
    end
    assign userData = beatData(drvCol, drvBeat);

    wire [BEAT_W-1:0] linkBeat =
        {mad_link_if_i.dataFall, mad_link_if_i.dataRise};
    // Link monitor; a beat is handled before a frame ending alongside
    always @(posedge clk) begin
        if (rst_n && mad_link_if_i.dataValid) begin
            `CHECK_EQ(linkBeat, beatData(mCol, mBeat))
            mBeat++;
            beatsSeen++;
        end
        if (rst_n && mad_link_if_i.ctlEn && mCnt == FRAME_BITS - 1) begin
            mFrame = {mSh, mad_link_if_i.ctlBit};
            mExp = (mFrames < NUM_COLS) ? OP_COLSEL :
                (mFrames == NUM_COLS) ? OP_MIRCLK : OP_PARK;
            `CHECK_EQ(mFrame[FRAME_BITS-1 -: OP_W], mExp)
            if (mFrames < NUM_COLS) begin
                `CHECK_EQ(mFrame[COL_W-1:0], COL_W'(mFrames))
                mCol = mFrames;
                mBeat = 0;
            end
            mFrames++;
            mCnt = 0;
        end else if (rst_n && mad_link_if_i.ctlEn) begin
            mSh = {mSh[FRAME_BITS-3:0], mad_link_if_i.ctlBit};
            mCnt++;
        end
    end

    // One query; the answer lands one cycle later
    task automatic query(input int c, input int r, input mad_tilt_t exp);
        @(posedge clk);
        qCol <= QCOL_W'(c);
        qRow <= QROW_W'(r);
        @(posedge clk);
        #1;
        `CHECK_EQ(qTilt, exp)
    endtask : query
    task automatic wrapUp();
        $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrapUp
    task automatic timedOut();
        failCount++;
        $display("Error at %0t: wait ran out, got %h expected %h",
            $time, 1'b0, 1'b1);
        wrapUp();
    endtask : timedOut

    // ******************************************************
    // Main sequence
    // ******************************************************
    initial begin
        int i;
        repeat (4) @(posedge clk);
        `CHECK_EQ(parked, 1'b1)
        `CHECK_EQ(qTilt, TILT_FLAT)
        rst_n <= 1'b1;
        query(0, 0, TILT_OFF);
        query(BORDER, BORDER, TILT_FLAT);
        @(posedge clk);
        userValid <= 1'b1;
        burstMode <= 1'b1;
        for (i = 0; i < 2000 && mFrames < 3; i++) @(posedge clk);
        if (mFrames < 3) timedOut();
        query(BORDER, BORDER, TILT_FLAT);
        // Writes plus sweep take about 55k cycles
        for (i = 0; i < 90000 && patDone !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (patDone !== 1'b1) timedOut();
        `CHECK_EQ(parked, 1'b0)
        `CHECK_EQ(beatsSeen, NUM_WORDS)
        `CHECK_EQ(mFrames, NUM_COLS + 1)
        `CHECK_EQ(burstCount, PCNT_W'(1))
        for (int j = 0; j < 6; j++) begin
            query(tc[j] + BORDER, tr[j] + BORDER,
                cellBit(tc[j], tr[j]) ? TILT_ON : TILT_OFF);
            query(bc[j], br[j], TILT_OFF);
        end
        @(posedge clk);
        parkReq <= 1'b1;
        burstRestart <= 1'b1;
        @(posedge clk);
        parkReq <= 1'b0;
        burstRestart <= 1'b0;
        for (i = 0; i < 100 && parked !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (parked !== 1'b1) timedOut();
        `CHECK_EQ(burstCount, PCNT_W'(0))
        query(BORDER, BORDER, TILT_FLAT);
        query(BORDER + 911, BORDER + 1139, TILT_FLAT);
        query(931, 0, TILT_OFF);
        wrapUp();
    end
endmodule : mad_tb
